// [pkg/setpoint_pkg.sv]
// setpoint_pkg: constants, link timing and the shared CRC-8 for the
// charge-setpoint broadcast link.
// assumes one 40 MHz system clock on both ends of the link.
`default_nettype none

package setpoint_pkg;

  // system clock and the one-second time base
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned SECOND_NS         = 1_000_000_000;
  localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  WATCHDOG_S        = 8'hAF;  // 175 seconds

  // charger side: target address and command codes
  localparam logic [6:0]  CHARGER_ADDR  = 7'h09;
  localparam logic [7:0]  CMD_CURRENT   = 8'h14;
  localparam logic [7:0]  CMD_VOLTAGE   = 8'h15;
  localparam logic [15:0] CURRENT_RESET = 16'h0000;
  localparam logic [15:0] VOLTAGE_RESET = 16'h0000;
  localparam logic [15:0] CURRENT_MASK  = 16'h1FC0;  // bits 12..6
  localparam int unsigned CURRENT_STEP_MA = 64;      // weight of bit 6

  // gauge side: broadcast defaults
  localparam logic [7:0]  TARGET_RESET  = 8'hD4;
  localparam logic [7:0]  VPTR_RESET    = 8'h0C;
  localparam logic [7:0]  IPTR_RESET    = 8'h0A;
  localparam logic [7:0]  PACING_RESET  = 8'h0F;  // 15 seconds

  // gauge register offsets (byte addresses) and fields
  localparam logic [7:0]  OFS_CONTROL = 8'h00;
  localparam logic [7:0]  OFS_TARGET  = 8'h04;
  localparam logic [7:0]  OFS_VPTR    = 8'h08;
  localparam logic [7:0]  OFS_IPTR    = 8'h0C;
  localparam logic [7:0]  OFS_PACING  = 8'h10;
  localparam logic [7:0]  OFS_VOLTAGE = 8'h14;
  localparam logic [7:0]  OFS_CURRENT = 8'h18;
  localparam logic [7:0]  OFS_STATUS  = 8'h1C;
  localparam int unsigned STAT_NACK_BIT = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // bit timing: one bus bit is 16 system cycles, clock low for the first 8
  localparam logic [3:0]  SCL_RISE     = 4'h8;
  localparam logic [3:0]  SDA_SET      = 4'h2;
  localparam logic [3:0]  STOP_RELEASE = 4'hC;
  localparam logic [3:0]  SDA_SAMPLE   = 4'hE;
  localparam logic [3:0]  BIT_LAST     = 4'hF;
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  localparam logic [3:0]  ACK_DONE     = 4'h9;
  localparam logic [2:0]  PEC_IDX      = 3'h4;
  localparam logic [2:0]  FRAME_BYTES  = 3'h5;

  // packet error code, polynomial x^8+x^2+x+1, one byte at a time
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// [pkg/setpoint_link_if.sv]
// setpoint_link_if: the two open-drain wires between gauge and charger.
// assumes pull-ups: a wire is low while any end enables a low drive.
`default_nettype none

interface setpoint_link_if;
  logic g_scl_out;
  logic g_scl_oe;
  logic g_sda_out;
  logic g_sda_oe;
  logic c_sda_out;
  logic c_sda_oe;
  logic scl;
  logic sda;

  // wired-and resolution of the bus
  assign scl = !(g_scl_oe && !g_scl_out);
  assign sda = !(g_sda_oe && !g_sda_out) && !(c_sda_oe && !c_sda_out);

  modport gauge (output g_scl_out, output g_scl_oe, output g_sda_out, output g_sda_oe,
                 input scl, input sda);
  modport charger (output c_sda_out, output c_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// [hw/charger_setpoint_port.sv]
// charger_setpoint_port: bus target that takes charge setpoint writes,
// keeps the current and voltage setpoints and runs the refresh watchdog.
// assumes a gauge that writes address, command, two data bytes and PEC.
//
// Overview of operation
// - gauge writes every bit of both words
// - charger stores reserved current bits as zero
// - charge current resolves in 64 mA steps
// - precharge option gives reduced rate below 64 mA
// - charger setpoints are pure two-byte registers
// - gauge holds charger 7-bit address, no R/W
// - pointers name lower register of each pair
// - watchdog clears setpoints after 175 s unrefreshed
// - pacing period shorter than charger watchdog
// - pacing byte sets period 0..255 s, default 15
// - broadcast disabled after reset
// - target address byte defaults to D4 hex
// - voltage pointer 0C, current pointer 0A defaults
// - charger takes current at command 14 hex
// - current bits 12..6 weigh 4096..64 mA
// - current bits 15..13 set means invalid write
// - charge current resets to zero
// - frame: command, low byte, high byte, PEC
`default_nettype none

module charger_setpoint_port
  import setpoint_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_SECOND
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // link
  setpoint_link_if.charger link,
  // setpoints and events
  output logic [15:0]      CHARGE_CURRENT,
  output logic [15:0]      CHARGE_VOLTAGE,
  output logic             SETPOINT_WRITTEN,
  output logic             INVALID_WRITE,
  output logic             WATCHDOG_EXPIRED
);

  typedef enum logic [2:0] {C_IDLE = 3'h1, C_RECV = 3'h2, C_SKIP = 3'h4} cstate_t;

  typedef struct packed {
    cstate_t     st;
    logic        scl_m, scl_s, scl_p;
    logic        sda_m, sda_s, sda_p;
    logic [3:0]  bitn;
    logic [2:0]  idx;
    logic [7:0]  shreg, cmd, lo, hi, crc;
    logic        pec_ok, sda_oe;
    logic [15:0] curr, volt;
    logic [31:0] presc;
    logic [7:0]  secs;
    logic        updated, invalid, expired;
  } charger_t;

  charger_t s;
  charger_t n;
  logic     start_c;
  logic     stop_c;
  logic     rise;
  logic     fall;

  // bus conditions seen on the synchronised wires only
  assign start_c = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
  assign stop_c  = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
  assign rise    = s.scl_s && !s.scl_p;
  assign fall    = !s.scl_s && s.scl_p;

  always_comb
  begin
    n = s;
    n.updated = 1'b0;
    n.invalid = 1'b0;
    n.expired = 1'b0;
    n.scl_m = link.scl;
    n.scl_s = s.scl_m;
    n.scl_p = s.scl_s;
    n.sda_m = link.sda;
    n.sda_s = s.sda_m;
    n.sda_p = s.sda_s;
    // watchdog: clears both setpoints when nobody refreshed them
    if (s.presc == CYCLES_PER_SEC - 1)
    begin
      n.presc = '0;
      if (s.secs == WATCHDOG_S - 8'h01)
      begin
        n.secs    = '0;
        n.curr    = CURRENT_RESET;
        n.volt    = VOLTAGE_RESET;
        n.expired = 1'b1;
      end
      else
      begin
        n.secs = 8'(s.secs + 8'h01);
      end
    end
    else
    begin
      n.presc = 32'(s.presc + 32'h1);
    end
    // receive engine; a start always wins, even in the middle of a byte
    if (start_c)
    begin
      n.st     = C_RECV;
      n.idx    = '0;
      n.bitn   = '0;
      n.crc    = '0;
      n.pec_ok = 1'b0;
      n.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      // commit only a complete frame whose PEC matched
      if (s.st == C_RECV && s.idx == FRAME_BYTES && s.pec_ok)
      begin
        if (s.cmd == CMD_CURRENT)
        begin
          if (|s.hi[7:5])
          begin
            n.invalid = 1'b1;
          end
          else
          begin
            n.curr    = {s.hi, s.lo} & CURRENT_MASK;
            n.presc   = '0;
            n.secs    = '0;
            n.updated = 1'b1;
          end
        end
        else if (s.cmd == CMD_VOLTAGE)
        begin
          n.volt    = {s.hi, s.lo};
          n.presc   = '0;
          n.secs    = '0;
          n.updated = 1'b1;
        end
      end
      n.st     = C_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (s.st == C_RECV)
    begin
      if (rise && s.bitn < ACK_SLOT)
      begin
        n.shreg = {s.shreg[6:0], s.sda_s};
        n.bitn  = 4'(s.bitn + 4'h1);
      end
      else if (fall && s.bitn == ACK_SLOT)
      begin
        // byte complete: take it and acknowledge in the ninth slot
        n.bitn   = ACK_DONE;
        n.sda_oe = 1'b1;
        case (s.idx)
          3'h0:
          begin
            if (s.shreg != {CHARGER_ADDR, 1'b0})
            begin
              n.sda_oe = 1'b0;
              n.st     = C_SKIP;
            end
          end
          3'h1: n.cmd = s.shreg;
          3'h2: n.lo = s.shreg;
          3'h3: n.hi = s.shreg;
          3'h4: n.pec_ok = (s.shreg == s.crc);
          default:
          begin
            n.sda_oe = 1'b0;
            n.st     = C_SKIP;
          end
        endcase
        if (s.idx < PEC_IDX)
        begin
          n.crc = crc8(s.crc, s.shreg);
        end
      end
      else if (fall && s.bitn == ACK_DONE)
      begin
        n.sda_oe = 1'b0;
        n.bitn   = '0;
        n.idx    = 3'(s.idx + 3'h1);
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s       <= '0;
      s.st    <= C_IDLE;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_p <= 1'b1;
      s.curr  <= CURRENT_RESET;
      s.volt  <= VOLTAGE_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign link.c_sda_out   = 1'b0;
  assign link.c_sda_oe    = s.sda_oe;
  assign CHARGE_CURRENT   = s.curr;
  assign CHARGE_VOLTAGE   = s.volt;
  assign SETPOINT_WRITTEN = s.updated;
  assign INVALID_WRITE    = s.invalid;
  assign WATCHDOG_EXPIRED = s.expired;

endmodule

`default_nettype wire

// [hw/gauge_setpoint_broadcaster.sv]
// gauge_setpoint_broadcaster: bus master that pushes the charge current
// and voltage setpoints to the charger at a programmable pacing period.
// assumes an AXI4-Lite master for setup and pull-ups on the link wires.
`default_nettype none

module gauge_setpoint_broadcaster
  import setpoint_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_SECOND
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // link
  setpoint_link_if.gauge   link,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  typedef enum logic [3:0] {G_IDLE = 4'h1, G_START = 4'h2, G_BYTE = 4'h4, G_STOP = 4'h8} gstate_t;

  typedef struct packed {
    gstate_t     st;
    logic [3:0]  cnt, bitn;
    logic [2:0]  idx;
    logic        frame, ackbad, skip;
    logic [7:0]  shreg, crc;
    logic [15:0] word, volt_snap;
    logic [31:0] presc;
    logic [7:0]  secs;
    logic        scl_oe, sda_oe, sda_m, sda_s;
    logic        enable, pchg_sel, pchg_region, busy, nack;
    logic [7:0]  tgt, vptr, iptr, pacing;
    logic [15:0] volt, curr;
    logic        aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
  } gauge_t;

  gauge_t s;
  gauge_t n;
  logic   nack_set;
  logic   nack_clr;

  // decoding shared by the read and the write path
  function automatic logic known(input logic [7:0] a);
    return a == OFS_CONTROL || a == OFS_TARGET || a == OFS_VPTR || a == OFS_IPTR ||
           a == OFS_PACING || a == OFS_VOLTAGE || a == OFS_CURRENT || a == OFS_STATUS;
  endfunction

  function automatic logic [31:0] rd_value(input gauge_t g, input logic [7:0] a);
    case (a)
      OFS_CONTROL: return {29'h0, g.pchg_region, g.pchg_sel, g.enable};
      OFS_TARGET:  return {24'h0, g.tgt};
      OFS_VPTR:    return {24'h0, g.vptr};
      OFS_IPTR:    return {24'h0, g.iptr};
      OFS_PACING:  return {24'h0, g.pacing};
      OFS_VOLTAGE: return {16'h0, g.volt};
      OFS_CURRENT: return {16'h0, g.curr};
      OFS_STATUS:  return {30'h0, g.nack, g.busy};
      default:     return 32'h0;
    endcase
  endfunction

  // byte k of the frame under way; the PEC byte closes it
  function automatic logic [7:0] frame_byte(input gauge_t g, input logic [2:0] k);
    case (k)
      3'h0:    return {g.tgt[6:0], 1'b0};
      3'h1:    return g.frame ? g.vptr : g.iptr;
      3'h2:    return g.word[7:0];
      3'h3:    return g.word[15:8];
      default: return g.crc;
    endcase
  endfunction

  always_comb
  begin
    n = s;
    nack_set = 1'b0;
    nack_clr = 1'b0;
    n.sda_m = link.sda;
    n.sda_s = s.sda_m;
    // register writes: address and data may come in either order
    if (S_AXI_AWVALID && s.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY)
    begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = known(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.wstrb[0])
      begin
        case (s.awaddr)
          OFS_CONTROL: {n.pchg_region, n.pchg_sel, n.enable} = s.wdata[2:0];
          OFS_TARGET:  n.tgt = s.wdata[7:0];
          OFS_VPTR:    n.vptr = s.wdata[7:0];
          OFS_IPTR:    n.iptr = s.wdata[7:0];
          OFS_PACING:  n.pacing = s.wdata[7:0];
          OFS_VOLTAGE: n.volt[7:0] = s.wdata[7:0];
          OFS_CURRENT: n.curr[7:0] = s.wdata[7:0];
          OFS_STATUS:  nack_clr = s.wdata[STAT_NACK_BIT];
          default:     ;
        endcase
      end
      if (s.wstrb[1] && s.awaddr == OFS_VOLTAGE)
      begin
        n.volt[15:8] = s.wdata[15:8];
      end
      if (s.wstrb[1] && s.awaddr == OFS_CURRENT)
      begin
        n.curr[15:8] = s.wdata[15:8];
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    // register reads answer one cycle after the address is taken
    if (s.rvalid && S_AXI_RREADY)
    begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && s.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = rd_value(s, S_AXI_ARADDR);
      n.rresp  = known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    // broadcast engine
    case (s.st)
      G_IDLE:
      begin
        if (!s.enable)
        begin
          n.presc = '0;
          n.secs  = '0;
        end
        else if (s.secs >= s.pacing)
        begin
          n.st        = G_START;
          n.cnt       = '0;
          n.frame     = 1'b0;
          n.ackbad    = 1'b0;
          n.busy      = 1'b1;
          n.presc     = '0;
          n.secs      = '0;
          n.skip      = !s.skip;
          // every other current word is zero: halves the precharge rate
          n.word      = (s.pchg_sel && s.pchg_region && s.skip) ? 16'h0000 : s.curr;
          n.volt_snap = s.volt;
        end
        else if (s.presc == CYCLES_PER_SEC - 1)
        begin
          n.presc = '0;
          n.secs  = 8'(s.secs + 8'h01);
        end
        else
        begin
          n.presc = 32'(s.presc + 32'h1);
        end
      end
      G_START:
      begin
        n.cnt = 4'(s.cnt + 4'h1);
        if (s.cnt == SCL_RISE)
        begin
          n.sda_oe = 1'b1;
        end
        if (s.cnt == BIT_LAST)
        begin
          n.st    = G_BYTE;
          n.idx   = '0;
          n.bitn  = '0;
          n.shreg = frame_byte(s, 3'h0);
          n.crc   = crc8(8'h00, frame_byte(s, 3'h0));
        end
      end
      G_BYTE:
      begin
        n.cnt = 4'(s.cnt + 4'h1);
        // data changes well inside the low half of the clock
        if (s.cnt == SDA_SET)
        begin
          n.sda_oe = (s.bitn < ACK_SLOT) && !s.shreg[7];
        end
        if (s.cnt == SDA_SAMPLE && s.bitn == ACK_SLOT && s.sda_s)
        begin
          n.ackbad = 1'b1;
          nack_set = 1'b1;
        end
        if (s.cnt == BIT_LAST)
        begin
          if (s.bitn != ACK_SLOT)
          begin
            n.shreg = {s.shreg[6:0], 1'b0};
            n.bitn  = 4'(s.bitn + 4'h1);
          end
          else if (n.ackbad || s.idx == PEC_IDX)
          begin
            n.st = G_STOP;
          end
          else
          begin
            n.idx   = 3'(s.idx + 3'h1);
            n.bitn  = '0;
            n.shreg = frame_byte(s, 3'(s.idx + 3'h1));
            if (s.idx + 3'h1 < PEC_IDX)
            begin
              n.crc = crc8(s.crc, frame_byte(s, 3'(s.idx + 3'h1)));
            end
          end
        end
      end
      G_STOP:
      begin
        n.cnt = 4'(s.cnt + 4'h1);
        if (s.cnt == SDA_SET)
        begin
          n.sda_oe = 1'b1;
        end
        if (s.cnt == STOP_RELEASE)
        begin
          n.sda_oe = 1'b0;
        end
        if (s.cnt == BIT_LAST)
        begin
          if (!s.ackbad && !s.frame)
          begin
            n.st    = G_START;
            n.frame = 1'b1;
            n.word  = s.volt_snap;
          end
          else
          begin
            n.st   = G_IDLE;
            n.busy = 1'b0;
          end
        end
      end
      default: n.st = G_IDLE;
    endcase
    // a refused acknowledge in the clearing cycle still sets the flag
    n.nack   = (s.nack && !nack_clr) || nack_set;
    n.scl_oe = (n.st == G_BYTE || n.st == G_STOP) && n.cnt < SCL_RISE;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s        <= '0;
      s.st     <= G_IDLE;
      s.sda_m  <= 1'b1;
      s.sda_s  <= 1'b1;
      s.tgt    <= TARGET_RESET;
      s.vptr   <= VPTR_RESET;
      s.iptr   <= IPTR_RESET;
      s.pacing <= PACING_RESET;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign link.g_scl_out = 1'b0;
  assign link.g_scl_oe  = s.scl_oe;
  assign link.g_sda_out = 1'b0;
  assign link.g_sda_oe  = s.sda_oe;
  assign S_AXI_AWREADY  = s.awready;
  assign S_AXI_WREADY   = s.wready;
  assign S_AXI_BRESP    = s.bresp;
  assign S_AXI_BVALID   = s.bvalid;
  assign S_AXI_ARREADY  = s.arready;
  assign S_AXI_RDATA    = s.rdata;
  assign S_AXI_RRESP    = s.rresp;
  assign S_AXI_RVALID   = s.rvalid;

endmodule

`default_nettype wire

// [test/setpoint_link_monitor.sv]
// setpoint_link_monitor: wire-level checks on the gauge-charger link.
// assumes the raw signals of setpoint_link_if and the 40 MHz system clock.
`default_nettype none

module setpoint_link_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link signals
  input wire logic g_scl_out,
  input wire logic g_scl_oe,
  input wire logic g_sda_out,
  input wire logic g_sda_oe,
  input wire logic c_sda_out,
  input wire logic c_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // one bus bit is eight cycles low then eight high
  sequence scl_high_run;
    scl [*8];
  endsequence
  sequence scl_low_run;
    !scl [*8] ##1 scl;
  endsequence

  a_scl_high_len: assert property ($rose(scl) |-> scl_high_run) else $error("clock high too short");
  a_scl_low_len: assert property ($fell(scl) |-> scl_low_run) else $error("clock low length wrong");
  a_ack_rise_low: assert property ($rose(c_sda_oe) |-> !scl) else $error("ack raised with clock high");
  a_ack_fall_low: assert property ($fell(c_sda_oe) |-> !scl) else $error("ack dropped with clock high");
  a_ack_hold_min: assert property ($rose(c_sda_oe) |-> c_sda_oe [*8]) else $error("ack too short");
  a_ack_over_high: assert property ($rose(scl) && c_sda_oe |-> c_sda_oe throughout scl_high_run)
    else $error("ack lost in high phase");
  // open drain: ends only ever pull low, never drive high
  a_drive_open_drain: assert property (!(g_scl_out || g_sda_out || c_sda_out))
    else $error("link driven high");
  a_idle_after_reset: assert property ($fell(SYS_RST) |-> (!g_scl_oe && !c_sda_oe) [*8])
    else $error("link busy after reset");
endmodule

`default_nettype wire

// [test/testbench.sv]
// testbench: gauge and charger joined by the link, gauge set up over AXI4-Lite.
// assumes seconds shortened to 20 cycles on both ends.
`default_nettype none

module testbench
  import setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPS = 20;

  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0]  r;
  logic [15:0] cur, vol;
  logic        written, invalid, wdog;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t0;

  // clock and a free cycle count for timing checks
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;

  setpoint_link_if link ();
  gauge_setpoint_broadcaster #(.CYCLES_PER_SEC(CPS)) gauge_setpoint_broadcaster_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .link(link),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  charger_setpoint_port #(.CYCLES_PER_SEC(CPS)) charger_setpoint_port_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .link(link), .CHARGE_CURRENT(cur), .CHARGE_VOLTAGE(vol),
    .SETPOINT_WRITTEN(written), .INVALID_WRITE(invalid), .WATCHDOG_EXPIRED(wdog));
  setpoint_link_monitor setpoint_link_monitor_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .g_scl_out(link.g_scl_out), .g_scl_oe(link.g_scl_oe),
    .g_sda_out(link.g_sda_out), .g_sda_oe(link.g_sda_oe), .c_sda_out(link.c_sda_out),
    .c_sda_oe(link.c_sda_oe), .scl(link.scl), .sda(link.sda));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // a hung wait ends the run as a failure
  task automatic hang(input string name);
    chk(name, 32'h0, 32'h1);
    end_sim();
  endtask

  // write: address and data offered together, bready held until the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge CLK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang("write response");
    // one idle edge so a following call never raises bready again in this step
    @(posedge CLK);
    chk("write resp", bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit done;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge CLK);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang("read response");
    // one idle edge so a following call never raises rready again in this step
    @(posedge CLK);
  endtask

  // waits for a charger pulse: 0 written, 1 invalid, 2 watchdog
  task automatic wait_ev(input int k, input int lim);
    bit hit;
    hit = 0;
    for (int n = 0; n < lim && !hit; n++)
    begin
      @(posedge CLK);
      hit = (k == 0) ? (written === 1'b1) : (k == 1) ? (invalid === 1'b1) : (wdog === 1'b1);
    end
    if (!hit) hang("charger event");
  endtask

  // polls the gauge status until the masked bits match
  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    d = ~want;
    for (int n = 0; n < 300 && (d & mask) !== want; n++) rd(OFS_STATUS, d, r);
    chk("status", d & mask, want);
  endtask

  initial
  begin
    logic [7:0]  ofs [5] = '{OFS_CONTROL, OFS_TARGET, OFS_VPTR, OFS_IPTR, OFS_PACING};
    logic [31:0] rst [5] = '{32'h0, 32'hD4, 32'h0C, 32'h0A, 32'h0F};
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    for (int i = 0; i < 5; i++)
    begin
      rd(ofs[i], d, r);
      chk("gauge reset value", d, rst[i]);
    end
    rd(8'h40, d, r);
    chk("unmapped resp", r, RESP_SLVERR);
    chk("current at reset", cur, CURRENT_RESET);
    $display("test reset values done");
    // a full broadcast with reserved current bits set
    wr(OFS_TARGET, CHARGER_ADDR);
    wr(OFS_IPTR, CMD_CURRENT);
    wr(OFS_VPTR, CMD_VOLTAGE);
    wr(OFS_PACING, 32'h2);
    wr(OFS_CURRENT, 32'h09C4);
    wr(OFS_VOLTAGE, 32'h20D0);
    rd(OFS_CURRENT, d, r);
    chk("current word", d, 32'h09C4);
    wr(OFS_CONTROL, 32'h1);
    wait_ev(0, 3000);
    chk("current", cur, 16'h09C0);
    wait_ev(0, 3000);
    chk("voltage", vol, 16'h20D0);
    // precharge mode: the next broadcast sends zero current, the one after the word
    wr(OFS_CONTROL, 32'h7);
    wait_ev(0, 3000);
    chk("precharge current off", cur, 16'h0000);
    wait_ev(0, 3000);
    wait_ev(0, 3000);
    chk("precharge current on", cur, 16'h09C0);
    wr(OFS_CONTROL, 32'h0);
    $display("test broadcast done");
    // top reserved bits make the current word invalid
    wr(OFS_CURRENT, 32'hE040);
    wr(OFS_CONTROL, 32'h1);
    wait_ev(1, 3000);
    chk("current kept", cur, 16'h09C0);
    wait_ev(0, 3000);
    t0 = cyc;
    wr(OFS_CONTROL, 32'h0);
    $display("test invalid write done");
    // wrong target: no acknowledge, sticky flag, write one clears
    wr(OFS_TARGET, 32'h6B);
    wr(OFS_CONTROL, 32'h1);
    poll(32'h2, 32'h2);
    wr(OFS_CONTROL, 32'h0);
    poll(32'h1, 32'h0);
    wr(OFS_STATUS, 32'h2);
    poll(32'h2, 32'h0);
    $display("test no acknowledge done");
    // no refresh for 175 seconds clears both setpoints
    wait_ev(2, 5000);
    chk("watchdog time", 32'((cyc - t0) inside {[175 * CPS - 20 : 175 * CPS + 25]}), 32'h1);
    chk("current cleared", cur, 16'h0000);
    chk("voltage cleared", vol, 16'h0000);
    $display("test watchdog done");
    end_sim();
  end
endmodule

`default_nettype wire
